/* rtl/fpc_pkg.sv */
`default_nettype none
package fpc_pkg;
  // Lane count and bus widths.
  localparam int NUM_LANES = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int IDX_W     = 6;
  localparam int IDX_LSB   = 2;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CTRL   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_STAT1  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STAT2  = 6'h08;
  localparam logic [IDX_W-1:0] IDX_TXDIS  = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SIGDET = 6'h0a;
  // Field positions.
  localparam int BIT_RESET       = 15;
  localparam int BIT_AUTO_OFF    = 0;
  localparam int BIT_LOCAL_FAULT = 7;
  localparam int BIT_TX_FAULT    = 11;
  localparam int BIT_RX_FAULT    = 10;
  localparam int BIT_GLOBAL      = 0;
  localparam int BIT_LANE0       = 1;
  // Reset values.
  localparam logic [NUM_LANES-1:0] LANES_RST = 4'h0;
  localparam logic                 FLAG_RST  = 1'h0;
  localparam logic [DATA_W-1:0]    WORD_RST  = 32'h0000_0000;
endpackage
`default_nettype wire

/* rtl/fpc_sync.sv */
`default_nettype none
// Two-stage synchroniser for pin levels; only the second stage is read.
module fpc_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // First stage, read only by the second stage.
  logic [W-1:0] sync_q;  // Second stage, safe for logic.

  // Both stages clear to zero so nothing looks present before signal arrives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

/* rtl/fpc_lane_drv.sv */
`default_nettype none
// One lane transmit driver stage with its own disable.
module fpc_lane_drv
  import fpc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic srst,
  input  wire logic tx_bit,
  input  wire logic tx_off,
  output logic      pos_leg,
  output logic      neg_leg,
  output logic      drive_en
);
  logic pos_q, pos_d;  // Positive leg level.
  logic neg_q, neg_d;  // Negative leg level.
  logic en_q,  en_d;   // Driver enable.

  // A one bit puts the positive leg above the negative one; off quiets both.
  always_comb begin
    en_d  = ~tx_off;
    pos_d = tx_bit & ~tx_off;
    neg_d = ~tx_bit & ~tx_off;
    if (srst) begin
      en_d  = FLAG_RST;
      pos_d = FLAG_RST;
      neg_d = FLAG_RST;
    end
  end

  // Driver levels start silent so nothing reaches the cable during reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= FLAG_RST;
      neg_q <= FLAG_RST;
      en_q  <= FLAG_RST;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
      en_q  <= en_d;
    end
  end

  assign pos_leg  = pos_q;
  assign neg_leg  = neg_q;
  assign drive_en = en_q;

  // A live lane shows the bit on its positive leg one cycle later.
  property p_tx_bit;
    @(posedge pclk) disable iff (!presetn)
      (!tx_off && !srst) |=> (pos_leg == $past(tx_bit)) && (neg_leg != pos_leg);
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("lane leg mismatch");

  // A disabled lane keeps both legs and its enable low.
  property p_tx_off;
    @(posedge pclk) disable iff (!presetn)
      tx_off |=> !drive_en && !pos_leg && !neg_leg;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("disabled lane drives");
endmodule
`default_nettype wire

/* rtl/fpc_top.sv */
// Register access over APB and the address map were decided locally.
`default_nettype none
// Four-lane copper medium control: lane data, signal detect, disables, faults.
module fpc_top
  import fpc_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB register port.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fpc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [fpc_pkg::DATA_W-1:0]  pwdata,
  output logic                             pready,
  output logic      [fpc_pkg::DATA_W-1:0]  prdata,
  output logic                             pslverr,
  // Transmit side.
  input  wire logic [fpc_pkg::NUM_LANES-1:0] lane_send_request,
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_tx_positive_leg,
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_tx_negative_leg,
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_tx_drive_en,
  // Receive side pins.
  input  wire logic [fpc_pkg::NUM_LANES-1:0] rx_level_pin,
  input  wire logic [fpc_pkg::NUM_LANES-1:0] rx_power_pin,
  input  wire logic [fpc_pkg::NUM_LANES-1:0] tx_fault_pin,
  input  wire logic [fpc_pkg::NUM_LANES-1:0] rx_fault_pin,
  // Toward the attachment sublayer.
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_receive_notice,
  output logic                               all_lanes_signal_status,
  output logic                               signal_change_notice,
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_signal_present,
  // Control and status levels.
  output logic                               all_lanes_tx_off,
  output logic      [fpc_pkg::NUM_LANES-1:0] lane_tx_off,
  output logic                               sublayer_reset_ctl,
  output logic                               local_fault_flag,
  output logic                               tx_path_fault_flag,
  output logic                               rx_path_fault_flag
);
  import fpc_pkg::*;

  // Synchronised pin levels.
  logic [NUM_LANES-1:0] rx_level_s;  // Received data comparators.
  logic [NUM_LANES-1:0] rx_power_s;  // Power detectors.
  logic [NUM_LANES-1:0] tx_fault_s;  // Driver fault monitors.
  logic [NUM_LANES-1:0] rx_fault_s;  // Receiver fault monitors.

  // Every pin crosses two flip-flops before any logic looks at it.
  fpc_sync #(.W(NUM_LANES)) u_sync_lvl (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (rx_level_pin),
    .sync_out (rx_level_s)
  );
  fpc_sync #(.W(NUM_LANES)) u_sync_pwr (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (rx_power_pin),
    .sync_out (rx_power_s)
  );
  fpc_sync #(.W(NUM_LANES)) u_sync_txf (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (tx_fault_pin),
    .sync_out (tx_fault_s)
  );
  fpc_sync #(.W(NUM_LANES)) u_sync_rxf (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (rx_fault_pin),
    .sync_out (rx_fault_s)
  );

  // Bus decode.
  logic             acc_wr;   // Write access phase.
  logic             acc_rd;   // Read access phase.
  logic             setup;    // Setup phase, used to latch read data.
  logic [IDX_W-1:0] idx;      // Register index from the address.
  logic             hit;      // Address maps to a register.
  logic [IDX_W-1:0] rd_idx;   // Same index, named for the read mux.

  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign idx    = paddr[IDX_LSB +: IDX_W];
  assign rd_idx = idx;
  assign hit    = (idx == IDX_CTRL) || (idx == IDX_STAT1) || (idx == IDX_STAT2)
                  || (idx == IDX_TXDIS) || (idx == IDX_SIGDET);

  // The slave never stretches; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Control and status state.
  logic                 srst_q, srst_d;          // Self-clearing sublayer reset.
  logic                 auto_q, auto_d;          // Fault turns drivers off.
  logic                 gdis_q, gdis_d;          // Global transmit off.
  logic [NUM_LANES-1:0] ldis_q, ldis_d;          // Per-lane transmit off.
  logic                 lflt_q, lflt_d;          // Latched local fault.
  logic                 tflt_q, tflt_d;          // Latched transmit fault.
  logic                 rflt_q, rflt_d;          // Latched receive fault.
  logic [NUM_LANES-1:0] rxd_q,  rxd_d;           // Delivered receive bits.
  logic [NUM_LANES-1:0] pres_q, pres_d;          // Per-lane signal present.
  logic                 glob_q, glob_d;          // Global signal status.
  logic                 chg_q,  chg_d;           // One-cycle change pulse.
  logic [DATA_W-1:0]    rdat_q, rdat_d;          // Read data register.
  logic [DATA_W-1:0]    rd_word;                 // Read mux output.
  logic                 tx_evt, rx_evt, any_evt; // Live fault events.

  // Fault events are the synchronised monitor levels.
  assign tx_evt  = |tx_fault_s;
  assign rx_evt  = |rx_fault_s;
  assign any_evt = tx_evt | rx_evt;

  // Read mux; reserved bits read as zero.
  always_comb begin
    rd_word = WORD_RST;
    unique case (rd_idx)
      IDX_CTRL: begin
        rd_word[BIT_RESET]    = srst_q;
        rd_word[BIT_AUTO_OFF] = auto_q;
      end
      IDX_STAT1: begin
        rd_word[BIT_LOCAL_FAULT] = lflt_q;
      end
      IDX_STAT2: begin
        rd_word[BIT_TX_FAULT] = tflt_q;
        rd_word[BIT_RX_FAULT] = rflt_q;
      end
      IDX_TXDIS: begin
        rd_word[BIT_GLOBAL]                  = gdis_q;
        rd_word[BIT_LANE0 +: NUM_LANES]      = ldis_q;
      end
      IDX_SIGDET: begin
        rd_word[BIT_GLOBAL]                  = glob_q;
        rd_word[BIT_LANE0 +: NUM_LANES]      = pres_q;
      end
      default: begin
        rd_word = WORD_RST;
      end
    endcase
  end

  // Next values of the management registers. Hardware sets win over
  // software writes and over read-clears in the same cycle; a fault only in a flag read's setup cycle is cleared unread.
  always_comb begin
    srst_d = acc_wr && (idx == IDX_CTRL) && pwdata[BIT_RESET];
    auto_d = auto_q;
    gdis_d = gdis_q;
    ldis_d = ldis_q;
    if (acc_wr && (idx == IDX_CTRL)) begin
      auto_d = pwdata[BIT_AUTO_OFF];
    end
    // Software is the means of disabling each lane on its own.
    if (acc_wr && (idx == IDX_TXDIS)) begin
      gdis_d = pwdata[BIT_GLOBAL];
      ldis_d = pwdata[BIT_LANE0 +: NUM_LANES];
    end
    // Optional automatic shutdown on a local fault.
    if (auto_q && any_evt) begin
      gdis_d = 1'b1;
      ldis_d = {NUM_LANES{1'b1}};
    end
    // Status flags latch high and clear when read.
    lflt_d = ((acc_rd && idx == IDX_STAT1) ? FLAG_RST : lflt_q) | any_evt;
    tflt_d = ((acc_rd && idx == IDX_STAT2) ? FLAG_RST : tflt_q) | tx_evt;
    rflt_d = ((acc_rd && idx == IDX_STAT2) ? FLAG_RST : rflt_q) | rx_evt;
    // Sublayer reset clears control; a live fault still sets its flag.
    if (srst_q) begin
      auto_d = FLAG_RST;
      gdis_d = FLAG_RST;
      ldis_d = LANES_RST;
      lflt_d = any_evt;
      tflt_d = tx_evt;
      rflt_d = rx_evt;
    end
    // Read data is captured in setup so it stands through access.
    rdat_d = setup ? rd_word : rdat_q;
  end

  // Management registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_q <= FLAG_RST;
      auto_q <= FLAG_RST;
      gdis_q <= FLAG_RST;
      ldis_q <= LANES_RST;
      lflt_q <= FLAG_RST;
      tflt_q <= FLAG_RST;
      rflt_q <= FLAG_RST;
      rdat_q <= WORD_RST;
    end else begin
      srst_q <= srst_d;
      auto_q <= auto_d;
      gdis_q <= gdis_d;
      ldis_q <= ldis_d;
      lflt_q <= lflt_d;
      tflt_q <= tflt_d;
      rflt_q <= rflt_d;
      rdat_q <= rdat_d;
    end
  end

  // Receive path and signal detect. A lane is present when its power
  // detector says so; no check of signal compliance is made, which the
  // partner must keep in mind when status reads OK on a poor link.
  always_comb begin
    rxd_d  = rx_level_s;
    pres_d = rx_power_s;
    glob_d = &pres_d;
    chg_d  = glob_d ^ glob_q;
    if (srst_q) begin
      pres_d = LANES_RST;
      glob_d = FLAG_RST;
      chg_d  = glob_q;
    end
  end

  // Receive bits are not reset by the sublayer reset: they carry no state,
  // and the partner ignores them while status reads FAIL.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_q  <= LANES_RST;
      pres_q <= LANES_RST;
      glob_q <= FLAG_RST;
      chg_q  <= FLAG_RST;
    end else begin
      rxd_q  <= rxd_d;
      pres_q <= pres_d;
      glob_q <= glob_d;
      chg_q  <= chg_d;
    end
  end

  // One driver stage per lane, silenced by either disable.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
      fpc_lane_drv u_drv (
        .pclk     (pclk),
        .presetn  (presetn),
        .srst     (srst_q),
        .tx_bit   (lane_send_request[gi]),
        .tx_off   (gdis_q | ldis_q[gi]),
        .pos_leg  (lane_tx_positive_leg[gi]),
        .neg_leg  (lane_tx_negative_leg[gi]),
        .drive_en (lane_tx_drive_en[gi])
      );
    end
  endgenerate

  // Outputs.
  assign prdata                  = rdat_q;
  assign lane_receive_notice     = rxd_q;
  assign lane_signal_present     = pres_q;
  assign all_lanes_signal_status = glob_q;
  assign signal_change_notice    = chg_q;
  assign all_lanes_tx_off        = gdis_q;
  assign lane_tx_off             = ldis_q;
  assign sublayer_reset_ctl      = srst_q;
  assign local_fault_flag        = lflt_q;
  assign tx_path_fault_flag      = tflt_q;
  assign rx_path_fault_flag      = rflt_q;

  // Received bits reach the partner three cycles after the pin, unchanged.
  property p_rx_order;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn, 3) |-> lane_receive_notice == $past(rx_level_pin, 3);
  endproperty
  a_rx_order: assert property (p_rx_order) else $error("rx lane bit wrong");

  // Global status is the AND of the lane detects, except in the cycle after a sublayer reset.
  property p_glob_and;
    @(posedge pclk) disable iff (!presetn)
      ($past(presetn, 3) && !$past(srst_q)) |-> all_lanes_signal_status == &$past(rx_power_pin, 3);
  endproperty
  a_glob_and: assert property (p_glob_and) else $error("global status not AND");

  // Every change of global status comes with a change pulse.
  property p_chg_pulse;
    @(posedge pclk) disable iff (!presetn)
      $changed(all_lanes_signal_status) |-> signal_change_notice;
  endproperty
  a_chg_pulse: assert property (p_chg_pulse) else $error("missing change pulse");

  // No change pulse without a change.
  property p_chg_only;
    @(posedge pclk) disable iff (!presetn)
      signal_change_notice |-> $changed(all_lanes_signal_status);
  endproperty
  a_chg_only: assert property (p_chg_only) else $error("spurious change pulse");

  // Lane detects follow the power pins with a three-cycle lag.
  property p_lane_det;
    @(posedge pclk) disable iff (!presetn)
      ($past(presetn, 3) && !$past(srst_q)) |-> lane_signal_present == $past(rx_power_pin, 3);
  endproperty
  a_lane_det: assert property (p_lane_det) else $error("lane detect lag");

  // Global off silences every driver one cycle later.
  property p_all_off;
    @(posedge pclk) disable iff (!presetn)
      all_lanes_tx_off |=> lane_tx_drive_en == LANES_RST;
  endproperty
  a_all_off: assert property (p_all_off) else $error("driver on under global off");

  // A fault event is latched on the next edge.
  property p_fault_set;
    @(posedge pclk) disable iff (!presetn)
      any_evt |=> local_fault_flag && (!$past(tx_evt) || tx_path_fault_flag);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  // Sublayer reset clears control and one cycle on the drivers.
  property p_srst;
    @(posedge pclk) disable iff (!presetn)
      sublayer_reset_ctl |=> !sublayer_reset_ctl && !all_lanes_tx_off && !(|lane_tx_drive_en)
                             && (local_fault_flag == $past(any_evt));
  endproperty
  a_srst: assert property (p_srst) else $error("sublayer reset ignored");

  // With automatic shutdown on, a fault turns all lanes off.
  property p_auto;
    @(posedge pclk) disable iff (!presetn)
      (auto_q && any_evt && !srst_q) |=> all_lanes_tx_off && (&lane_tx_off);
  endproperty
  a_auto: assert property (p_auto) else $error("fault did not disable");
endmodule
`default_nettype wire

/* testbench/fpc_peer_model.sv */
`default_nettype none
// Stand-in for the far side: the cable and link peer looped back onto our receiver,
// plus the attachment sublayer's reading of what is delivered to it.
module fpc_peer_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] pos_leg,
  input  wire logic [3:0] neg_leg,
  input  wire logic [3:0] drive_en,
  input  wire logic [3:0] rx_bits,
  input  wire logic       status_ok,
  output logic      [3:0] level_pin,
  output logic      [3:0] power_pin,
  output logic      [3:0] rx_view
);
  timeunit 1ns;
  timeprecision 1ps;

  // The cable adds one cycle; a silent lane shows no power and a level that toggles.
  // Toggling keeps a dead lane from looking like a steady stream of zeros.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_pin <= 4'h0;
      power_pin <= 4'h0;
    end else begin
      power_pin <= drive_en;
      for (int i = 0; i < 4; i++) begin
        level_pin[i] <= drive_en[i] ? (pos_leg[i] & ~neg_leg[i]) : ~level_pin[i];
      end
    end
  end

  // The sublayer reads every bit as zero while the link status is FAIL.
  assign rx_view = status_ok ? rx_bits : 4'h0;
endmodule
`default_nettype wire

/* testbench/four_lane_pmd_control_tb.sv */
`default_nettype none
// Compares two values, counts the check and reports a mismatch at once.
`define FPC_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module four_lane_pmd_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;

  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata;
  logic                 pready;
  logic [DATA_W-1:0]    prdata;
  logic                 pslverr;
  logic [3:0]           lane_send_request;
  logic [3:0]           pos;
  logic [3:0]           neg;
  logic [3:0]           drv_en;
  logic [3:0]           level_pin;
  logic [3:0]           power_pin;
  logic [3:0]           tx_fault_pin;
  logic [3:0]           rx_fault_pin;
  logic [3:0]           rx_bits;
  logic [3:0]           rx_view;
  logic                 status_ok;
  logic                 change;
  logic [3:0]           present;
  logic                 all_off;
  logic [3:0]           lane_off;
  logic                 srst_pulse;
  logic                 f_local;
  logic                 f_tx;
  logic                 f_rx;
  int                   err_count;
  int                   num_checks;
  int                   chg_count;
  int                   rst_count;
  int                   cycles;
  int                   c0;
  logic [3:0]           lb;

  fpc_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lane_send_request(lane_send_request), .lane_tx_positive_leg(pos),
    .lane_tx_negative_leg(neg), .lane_tx_drive_en(drv_en), .rx_level_pin(level_pin),
    .rx_power_pin(power_pin), .tx_fault_pin(tx_fault_pin), .rx_fault_pin(rx_fault_pin),
    .lane_receive_notice(rx_bits), .all_lanes_signal_status(status_ok),
    .signal_change_notice(change), .lane_signal_present(present),
    .all_lanes_tx_off(all_off), .lane_tx_off(lane_off), .sublayer_reset_ctl(srst_pulse),
    .local_fault_flag(f_local), .tx_path_fault_flag(f_tx), .rx_path_fault_flag(f_rx));

  fpc_peer_model peer (
    .pclk(pclk), .presetn(presetn), .pos_leg(pos), .neg_leg(neg), .drive_en(drv_en),
    .rx_bits(rx_bits), .status_ok(status_ok), .level_pin(level_pin),
    .power_pin(power_pin), .rx_view(rx_view));

  // Clock of 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Counts pulses so that a missed or doubled pulse shows up later.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (change === 1'b1) chg_count <= chg_count + 1;
    if (srst_pulse === 1'b1) rst_count <= rst_count + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Lets n edges pass, then samples where everything has settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One APB transfer; starts at the next edge so it never reuses a release edge.
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp,
                        input logic exp_err);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    `FPC_CHK(r, exp)
    `FPC_CHK(e, exp_err)
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lane_send_request, tx_fault_pin, rx_fault_pin} = '0;
    {err_count, num_checks, chg_count, rst_count, cycles} = '0;
    presetn = 1'b0;
    // Reset values, during reset and in every register but SIGDET, which reads all lanes present.
    repeat (5) @(posedge pclk);
    #1;
    `FPC_CHK({drv_en, pos, neg, pready}, 13'h0001)
    @(posedge pclk);
    presetn <= 1'b1;
    cyc(12);
    rd_chk(IDX_CTRL, WORD_RST, 1'b0);
    rd_chk(IDX_STAT1, WORD_RST, 1'b0);
    rd_chk(IDX_STAT2, WORD_RST, 1'b0);
    rd_chk(IDX_TXDIS, WORD_RST, 1'b0);
    rd_chk(IDX_SIGDET, 32'h0000_001f, 1'b0);
    $display("test reset done");
    // Every bit pattern goes out with the right polarity and comes back in order.
    for (int p = 0; p < 16; p++) begin
      @(posedge pclk);
      lane_send_request <= 4'(p);
      cyc(1);
      `FPC_CHK({pos, neg, drv_en}, {4'(p), ~4'(p), 4'hf})
      cyc(7);
      `FPC_CHK(rx_bits, 4'(p))
      `FPC_CHK({status_ok, present}, 5'h1f)
    end
    $display("test link done");
    // One lane off at a time: only that driver stops and the status falls.
    for (int i = 0; i < 4; i++) begin
      lb = 4'h1 << i;
      c0 = chg_count;
      wr(IDX_TXDIS, 32'({lb, 1'b0}));
      cyc(1);
      `FPC_CHK({drv_en, lane_off, all_off}, {~lb, lb, 1'b0})
      cyc(8);
      `FPC_CHK({status_ok, present}, {1'b0, ~lb})
      `FPC_CHK(rx_view, 4'h0)
      rd_chk(IDX_SIGDET, 32'({~lb, 1'b0}), 1'b0);
      wr(IDX_TXDIS, 32'h0000_0000);
      cyc(10);
      `FPC_CHK(status_ok, 1'b1)
      `FPC_CHK(chg_count - c0, 2)
    end
    $display("test lane disable done");
    // Global off silences every lane.
    wr(IDX_TXDIS, 32'h0000_0001);
    cyc(1);
    `FPC_CHK({drv_en, pos, neg, all_off}, 13'h0001)
    rd_chk(IDX_TXDIS, 32'h0000_0001, 1'b0);
    wr(IDX_TXDIS, 32'h0000_0000);
    cyc(10);
    $display("test global disable done");
    // A transmit fault with auto-off on, then a receive fault with it off.
    wr(IDX_CTRL, 32'h0000_0001);
    @(posedge pclk);
    tx_fault_pin <= 4'h4;
    cyc(2);
    @(posedge pclk);
    tx_fault_pin <= 4'h0;
    cyc(6);
    `FPC_CHK({f_local, f_tx, f_rx}, 3'b110)
    `FPC_CHK({all_off, lane_off, drv_en}, 9'h1f0)
    rd_chk(IDX_STAT1, 32'h0000_0080, 1'b0);
    rd_chk(IDX_STAT1, 32'h0000_0000, 1'b0);
    rd_chk(IDX_STAT2, 32'h0000_0800, 1'b0);
    wr(IDX_CTRL, 32'h0000_0000);
    wr(IDX_TXDIS, 32'h0000_0000);
    @(posedge pclk);
    rx_fault_pin <= 4'h1;
    cyc(2);
    @(posedge pclk);
    rx_fault_pin <= 4'h0;
    cyc(6);
    `FPC_CHK({f_local, f_tx, f_rx, all_off}, 4'b1010)
    rd_chk(IDX_STAT2, 32'h0000_0400, 1'b0);
    rd_chk(IDX_STAT1, 32'h0000_0080, 1'b0);
    $display("test faults done");
    // Sublayer reset clears the control state with a single pulse.
    wr(IDX_TXDIS, 32'h0000_001e);
    c0 = rst_count;
    wr(IDX_CTRL, 32'h0000_8001);
    cyc(4);
    `FPC_CHK(rst_count - c0, 1)
    `FPC_CHK(lane_off, 4'h0)
    rd_chk(IDX_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(IDX_TXDIS, 32'h0000_0000, 1'b0);
    $display("test sublayer reset done");
    // An unmapped word answers with an error and a write to it changes nothing.
    wr(6'h02, 32'hffff_ffff);
    rd_chk(6'h02, 32'h0000_0000, 1'b1);
    rd_chk(IDX_TXDIS, 32'h0000_0000, 1'b0);
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
